// [design/arf_result_format.sv]
// module: converter result capture, single/differential tag, alignment and completion flag
`timescale 1ns/10ps

module arf_result_format
	import arf_pkg::*;
#(
	parameter int RESULT_WIDTH = RES_W
)
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              convDone,
	input  wire logic [RES_W-1:0]  convCode,
	input  wire logic              convDiff,
	input  wire logic              leftAlignSelect,
	input  wire logic              ampInputShortSet,
	input  wire logic              doneFlagWriteOne,
	input  wire logic              doneVectorAck,
	output logic      [BYTE_W-1:0] resultLowByte,
	output logic      [BYTE_W-1:0] resultHighByte,
	output logic                   resultSignBit,
	output logic                   conversionDoneFlag,
	output logic                   ampInputShort,
	output logic                   resultIsDiff
);
	// ************************************************************
	// elaboration check
	// ************************************************************
	if (RESULT_WIDTH != RES_W) begin : g_width_check
		$error("arf_result_format: only a 10-bit result is supported");
	end

	// ************************************************************
	// state
	// ************************************************************
	logic [RES_W-1:0] result_r;
	arf_mode_t        mode_r;
	logic             flag_r;
	logic             short_r;
	logic [BYTE_W-1:0] highComb;
	logic [BYTE_W-1:0] lowComb;
	logic [BYTE_W-1:0] high_r;
	logic [BYTE_W-1:0] low_r;
	logic             alignShown_r;

	// captures the code as given; single-ended codes are unsigned and differential ones two's complement
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result_r <= RESULT_RST;
			mode_r   <= ARF_SINGLE;
		end else if (convDone) begin
			result_r <= convCode;
			mode_r   <= convDiff ? ARF_DIFF : ARF_SINGLE;
		end
	end

	// set wins over both clears
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flag_r <= FLAG_RST;
		end else if (convDone) begin
			flag_r <= 1'b1;
		end else if (doneFlagWriteOne || doneVectorAck) begin
			flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			short_r <= SHORT_RST;
		end else begin
			short_r <= ampInputShortSet;
		end
	end

	// ************************************************************
	// placement
	// ************************************************************
	arf_byte_placer u_placer (
		.result   (result_r),
		.leftAlign(leftAlignSelect),
		.highByte (highComb),
		.lowByte  (lowComb)
	);

	// bytes are registered; alignment reworks them from the held result each cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			high_r       <= '0;
			low_r        <= '0;
			alignShown_r <= LEFT_ALIGN_RST;
		end else begin
			high_r       <= highComb;
			low_r        <= lowComb;
			alignShown_r <= leftAlignSelect;
		end
	end

	assign resultHighByte     = high_r;
	assign resultLowByte      = low_r;
	// sign follows the placement the bytes were built with, so it never picks a stale bit
	assign resultSignBit      = alignShown_r ? high_r[HIGH_SIGN_POS_LEFT] : high_r[HIGH_SIGN_POS_RIGHT];
	assign conversionDoneFlag = flag_r;
	assign ampInputShort      = short_r;
	assign resultIsDiff       = (mode_r == ARF_DIFF);
endmodule // arf_result_format

// [design/arf_pkg.sv]
// package: constants for the converter result formatting block
package arf_pkg;
	localparam int RES_W              = 10;
	localparam int BYTE_W             = 8;
	localparam logic [9:0] CODE_GND   = 10'h000;
	localparam logic [9:0] CODE_FULL  = 10'h3FF;
	localparam logic [9:0] DIFF_MIN   = 10'h200;
	localparam logic [9:0] DIFF_MAX   = 10'h1FF;
	localparam logic [9:0] DIFF_ZERO  = 10'h000;
	localparam int SIGN_POS           = 9;
	localparam int HIGH_SIGN_POS_LEFT = 7;
	localparam int HIGH_SIGN_POS_RIGHT = 1;
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic LEFT_ALIGN_RST   = 1'b0;
	localparam logic SHORT_RST        = 1'b0;
	localparam logic FLAG_RST         = 1'b0;
	typedef enum logic [0:0] {
		ARF_SINGLE,
		ARF_DIFF
	} arf_mode_t;
endpackage

// [design/arf_byte_placer.sv]
// module: places a 10-bit result into a high and a low byte
`timescale 1ns/10ps
module arf_byte_placer
	import arf_pkg::*;
(
	input  wire logic [RES_W-1:0]  result,
	input  wire logic              leftAlign,
	output logic      [BYTE_W-1:0] highByte,
	output logic      [BYTE_W-1:0] lowByte
);
	always_comb begin
		if (leftAlign) begin
			highByte = result[9:2];
			lowByte  = {result[1:0], 6'h00};
		end else begin
			highByte = {6'h00, result[9:8]};
			lowByte  = result[7:0];
		end
	end
endmodule // arf_byte_placer

// [verif/arf_result_format_monitor.sv]
// checker: result formatting assertions
`timescale 1ns/10ps
module arf_result_format_monitor import arf_pkg::*; (
	input wire logic clk, sys_rst, convDone, convDiff, leftAlignSelect, ampInputShortSet, doneFlagWriteOne,
	input wire logic doneVectorAck, resultSignBit, conversionDoneFlag, ampInputShort, resultIsDiff,
	input wire logic [RES_W-1:0] convCode,
	input wire logic [BYTE_W-1:0] resultLowByte, resultHighByte);
	wire logic [15:0] resBytes = {resultHighByte, resultLowByte};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	flag_set_a: assert property (convDone |=> conversionDoneFlag) else $error("flag");
	flag_clr_a: assert property ((doneFlagWriteOne || doneVectorAck) && !convDone |=> !conversionDoneFlag)
		else $error("flag");
	right_place_a: assert property (convDone ##1 !leftAlignSelect |=> resBytes == {6'h0, $past(convCode, 2)})
		else $error("bytes");
	left_place_a: assert property (convDone ##1 leftAlignSelect |=> resBytes == {$past(convCode, 2), 6'h0})
		else $error("bytes");
	hold_bytes_a: assert property (!$past(convDone) && $stable(leftAlignSelect) |=> $stable(resBytes))
		else $error("bytes");
	sign_bit_a: assert property ($stable(leftAlignSelect) |-> resultSignBit == resBytes[leftAlignSelect ? 15 : 9])
		else $error("sign");
	diff_kind_a: assert property (convDone |=> resultIsDiff == $past(convDiff)) else $error("kind");
	input_short_a: assert property ($rose(ampInputShortSet) |=> ampInputShort) else $error("short");
endmodule // arf_result_format_monitor
bind arf_result_format arf_result_format_monitor mon_u (.*);

// [verif/arf_conv_model.sv]
// model: converter handing over a code one cycle after a start
`timescale 1ns/10ps
module arf_conv_model (
	input wire logic clk, go,
	input wire logic [10:0] req,
	output logic done,
	output logic [10:0] res);
	initial {done, res} = 12'h0;
	always @(posedge clk) begin
		// conversions are started only by the bench, never during other activity
		done <= go;
		res <= go ? req : ~res;
	end
endmodule // arf_conv_model

// [verif/arf_result_format_tb.sv]
// bench: result formatting testbench
`timescale 1ns/10ps
module arf_result_format_tb import arf_pkg::*;;
	logic clk = 1'b0, sys_rst = 1'b1, go = 1'b0, leftAlignSelect = 1'b0, ampInputShortSet = 1'b0;
	logic doneFlagWriteOne = 1'b0, doneVectorAck = 1'b0, convDone, convDiff, resultSignBit, conversionDoneFlag;
	logic ampInputShort, resultIsDiff;
	logic [10:0] req = 11'h0;
	logic [9:0] convCode;
	logic [7:0] resultLowByte, resultHighByte;
	int n_errors = 0, tests_run = 0, cyc = 0;
	always #10 clk = ~clk;
	always @(posedge clk) if (++cyc == 900) begin
		n_errors++;
		summarize();
	end
	arf_conv_model conv_u (.clk(clk), .go(go), .req(req), .done(convDone), .res({convDiff, convCode}));
	arf_result_format dut_u (.*);
	function automatic logic [15:0] place(logic [9:0] c, logic l);
		return l ? {c, 6'h0} : {6'h0, c};
	endfunction
	task automatic cmp(input logic [19:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h", $time, got);
		end
	endtask
	task automatic run(input logic [10:0] r, input logic l, input int w);
		@(posedge clk) {go, req, leftAlignSelect} <= {1'b1, r, l};
		@(posedge clk) go <= 1'b0;
		repeat (w) @(posedge clk);
		#1 cmp({conversionDoneFlag, resultIsDiff, resultSignBit, resultHighByte, resultLowByte}, {1'b1, r[10], r[9], place(r[9:0], l)});
		@(posedge clk) {leftAlignSelect, doneFlagWriteOne, doneVectorAck} <= {~l, l, ~l};
		@(posedge clk) {doneFlagWriteOne, doneVectorAck} <= 2'b00;
		#1 cmp({conversionDoneFlag, resultSignBit, resultHighByte, resultLowByte}, {1'b0, r[9], place(r[9:0], ~l)});
	endtask
	task automatic summarize();
		$display("errors %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		#1 cmp({conversionDoneFlag, resultHighByte, resultLowByte}, 20'h0);
		run(11'h670, 1'b1, 2);
		run(11'h429, 1'b1, 4);
		run(11'h3FF, 1'b0, 6);
		run(11'h000, 1'b1, 2);
		run(11'h600, 1'b0, 3);
		run(11'h5FF, 1'b1, 2);
		@(posedge clk) ampInputShortSet <= 1'b1;
		@(posedge clk) #1 cmp(ampInputShort, 1'b1);
		summarize();
	end
endmodule // arf_result_format_tb
